// ---- src/pdw_ctrl.sv ----
`timescale 1ns/1ps

module pdw_ctrl #(
    parameter logic [17:0] STAB_NORMAL_CYC = pdw_pkg::STAB_NORMAL_DEF
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    // External pins, asynchronous
    input  wire pdw_pkg::pdw_pins_t   pins,
    // From the CPU core
    input  wire logic                 sleep_exec,
    input  wire logic                 global_irq_enable_flag,
    input  wire pdw_pkg::pdw_io_req_t io_req,
    // Internal I/O read answer
    output logic                      io_hit,
    output logic [7:0]                io_rdata,
    // Power and clock control
    output pdw_pkg::pdw_pwr_t         pwr,
    output pdw_pkg::pdw_state_t       mode,
    // Resume actions, one-cycle pulses except bus_grant, which holds while the bus request stays active
    output logic                      nmi_ack_start,
    output logic [2:0]                irq_ack_start,
    output logic                      resume_next,
    output logic                      bus_grant
);
    import pdw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and NMI edge latch.
    logic [SYNC_W-1:0] pins_s;
    pdw_pins_t         pin_s;
    logic              nmi_prev_q;
    logic              nmi_pend_q;
    logic              nmi_pend_d;
    logic              nmi_fall;

    pdw_sync u_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .din     (pins),
        .dout    (pins_s)
    );

    assign pin_s    = pins_s;
    assign nmi_fall = nmi_prev_q & ~pin_s.nmi_n;

    // The latch is set on the falling edge and held until the acknowledge;
    // a new edge in the clearing cycle wins.
    always_comb begin
        nmi_pend_d = nmi_pend_q;
        if (nmi_ack_start) begin
            nmi_pend_d = 1'b0;
        end
        if (nmi_fall) begin
            nmi_pend_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nmi_prev_q <= 1'b1;
            nmi_pend_q <= 1'b0;
        end else begin
            nmi_prev_q <= pin_s.nmi_n;
            nmi_pend_q <= nmi_pend_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file in the relocatable internal I/O window.
    logic [7:0] ioc_q;
    logic [7:0] ioc_d;
    logic [7:0] ccr_q;
    logic [7:0] ccr_d;
    logic [7:0] itc_q;
    logic [7:0] itc_d;
    logic       hit_d;
    logic [7:0] rdata_d;
    logic       in_win;
    logic [5:0] ofs;

    assign ofs    = io_req.addr[5:0];
    assign in_win = (io_req.addr[15:8] == IO_HIGH_ZERO)
                 && (io_req.addr[7:6] == ioc_q[IOC_BASE_HI:IOC_BASE_LO]);

    always_comb begin
        ioc_d   = ioc_q;
        ccr_d   = ccr_q;
        itc_d   = itc_q;
        hit_d   = 1'b0;
        rdata_d = 8'h00;
        if (in_win && (io_req.wr || io_req.rd)) begin
            if (ofs == OFS_IO_CONTROL) begin
                hit_d   = 1'b1;
                rdata_d = ioc_q & IOC_WMASK;
                if (io_req.wr) begin
                    ioc_d = io_req.wdata & IOC_WMASK;
                end
            end else if (ofs == OFS_CPU_CONTROL) begin
                hit_d   = 1'b1;
                rdata_d = ccr_q;
                if (io_req.wr) begin
                    ccr_d = io_req.wdata;
                end
            end else if (ofs == OFS_IRQ_TRAP_CTRL) begin
                hit_d   = 1'b1;
                rdata_d = itc_q & ITC_WMASK;
                if (io_req.wr) begin
                    itc_d = io_req.wdata & ITC_WMASK;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ioc_q    <= IOC_RESET;
            ccr_q    <= CCR_RESET;
            itc_q    <= ITC_RESET;
            io_hit   <= 1'b0;
            io_rdata <= 8'h00;
        end else begin
            ioc_q    <= ioc_d;
            ccr_q    <= ccr_d;
            itc_q    <= itc_d;
            io_hit   <= hit_d;
            io_rdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake sources.
    logic [2:0] irq_act;
    logic       bus_act;
    logic       wake_lvl;

    // A disabled line is ignored regardless of the global flag.
    assign irq_act  = ~pin_s.irq_n & itc_q[ITC_EN_C:ITC_EN_A];
    assign bus_act  = ~pin_s.bus_request_in_n & ccr_q[CCR_BUS_WAKE];
    assign wake_lvl = (|irq_act) | bus_act;

    ////////////////////////////////////////////////////////////////////////////
    // Power state machine.
    pdw_state_t       state_d;
    pdw_pwr_t         pwr_d;
    logic             tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic             tmr_run;
    logic             tmr_done;
    logic             resume;
    logic             nmi_ack_d;
    logic [2:0]       irq_ack_d;
    logic             resume_next_d;
    logic             bus_grant_d;

    pdw_stab_timer u_timer (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .run      (tmr_run),
        .done     (tmr_done)
    );

    // The timer only advances in PDW_STAB and PDW_IDLE_WAIT, the waits before resuming.
    assign tmr_run = (mode == PDW_STAB) || (mode == PDW_IDLE_WAIT);

    always_comb begin
        state_d  = mode;
        tmr_load = 1'b0;
        tmr_val  = IDLE_EXIT_CYC;
        resume   = 1'b0;
        case (mode)
            PDW_RUN: begin
                if (sleep_exec) begin
                    tmr_load = 1'b1;
                    if (!ioc_q[IOC_STOP]) begin
                        state_d = PDW_SLEEP;
                    end else if (ccr_q[CCR_STANDBY]) begin
                        state_d = PDW_STANDBY;
                    end else if (ccr_q[CCR_QUICK]) begin
                        state_d = PDW_IDLE;
                    end else begin
                        state_d = PDW_SLEEP;
                    end
                end
            end
            PDW_SLEEP: begin
                if (nmi_pend_q || (|irq_act)) begin
                    resume = 1'b1;
                end
            end
            PDW_STANDBY: begin
                if (nmi_pend_q || wake_lvl) begin
                    state_d  = PDW_STAB;
                    tmr_load = 1'b1;
                    // Quick recovery trusts the oscillator to settle in 64 cycles.
                    tmr_val  = ccr_q[CCR_QUICK] ? STAB_QUICK_CYC
                                                : STAB_NORMAL_CYC;
                end
            end
            PDW_STAB: begin
                if (!nmi_pend_q && !wake_lvl) begin
                    state_d = PDW_STANDBY;
                end else if (tmr_done) begin
                    resume = 1'b1;
                end
            end
            PDW_IDLE: begin
                if (nmi_pend_q || (|irq_act) || !pin_s.bus_request_in_n) begin
                    state_d  = PDW_IDLE_WAIT;
                    tmr_load = 1'b1;
                    tmr_val  = IDLE_EXIT_CYC;
                end
            end
            PDW_IDLE_WAIT: begin
                if (tmr_done) begin
                    resume = 1'b1;
                end
            end
            default: begin
                state_d = PDW_RUN;
            end
        endcase
        if (resume) begin
            state_d = PDW_RUN;
        end
    end

    // Clock gating follows the next state so the outputs change with it.
    always_comb begin
        pwr_d.periph_stop = ioc_q[IOC_STOP];
        pwr_d.osc_en      = 1'b1;
        pwr_d.cpu_clk_en  = 1'b1;
        pwr_d.system_clock_output_en   = 1'b1;
        case (state_d)
            PDW_SLEEP: begin
                pwr_d.cpu_clk_en = 1'b0;
            end
            PDW_STANDBY: begin
                pwr_d.osc_en     = 1'b0;
                pwr_d.cpu_clk_en = 1'b0;
                pwr_d.system_clock_output_en  = 1'b0;
            end
            PDW_STAB, PDW_IDLE, PDW_IDLE_WAIT: begin
                pwr_d.cpu_clk_en = 1'b0;
                pwr_d.system_clock_output_en  = 1'b0;
            end
            default: begin
                pwr_d.cpu_clk_en = 1'b1;
            end
        endcase
    end

    // On resume the NMI takes precedence, then lines a, b, c in order.
    // With the flag clear a maskable wake only lets execution continue.
    always_comb begin
        nmi_ack_d     = 1'b0;
        irq_ack_d     = 3'b000;
        resume_next_d = 1'b0;
        bus_grant_d   = bus_grant && !pin_s.bus_request_in_n;
        if (resume) begin
            if (nmi_pend_q) begin
                nmi_ack_d = 1'b1;
            end else if ((|irq_act) && global_irq_enable_flag) begin
                if (irq_act[0]) begin
                    irq_ack_d = 3'b001;
                end else if (irq_act[1]) begin
                    irq_ack_d = 3'b010;
                end else begin
                    irq_ack_d = 3'b100;
                end
            end else begin
                resume_next_d = 1'b1;
            end
            bus_grant_d = !pin_s.bus_request_in_n;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode          <= PDW_RUN;
            pwr           <= '{osc_en: 1'b1, cpu_clk_en: 1'b1,
                               system_clock_output_en: 1'b1, periph_stop: 1'b0};
            nmi_ack_start <= 1'b0;
            irq_ack_start <= 3'b000;
            resume_next   <= 1'b0;
            bus_grant     <= 1'b0;
        end else begin
            mode          <= state_d;
            pwr           <= pwr_d;
            nmi_ack_start <= nmi_ack_d;
            irq_ack_start <= irq_ack_d;
            resume_next   <= resume_next_d;
            bus_grant     <= bus_grant_d;
        end
    end

endmodule

// ---- src/pdw_pkg.sv ----
package pdw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Internal I/O window.
    localparam logic [7:0] IO_HIGH_ZERO        = 8'h00;
    localparam logic [5:0] OFS_CPU_CONTROL     = 6'h1F;
    localparam logic [5:0] OFS_IRQ_TRAP_CTRL   = 6'h34;
    localparam logic [5:0] OFS_IO_CONTROL      = 6'h3F;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int IOC_BASE_HI   = 7;
    localparam int IOC_BASE_LO   = 6;
    localparam int IOC_STOP      = 5;
    localparam int CCR_STANDBY   = 6;
    localparam int CCR_BUS_WAKE  = 5;
    localparam int CCR_QUICK     = 3;
    localparam int ITC_EN_A      = 0;
    localparam int ITC_EN_C      = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and writable masks.
    localparam logic [7:0] IOC_RESET   = 8'h00;
    localparam logic [7:0] IOC_WMASK   = 8'hE0;
    localparam logic [7:0] CCR_RESET   = 8'h00;
    localparam logic [7:0] ITC_RESET   = 8'h00;
    localparam logic [7:0] ITC_WMASK   = 8'h07;

    ////////////////////////////////////////////////////////////////////////////
    // Timing counts, in clk_sys cycles, and the timer and synchroniser widths.
    localparam int         TMR_W           = 18;
    localparam logic [17:0] STAB_NORMAL_DEF = 18'h20000;
    localparam logic [17:0] STAB_QUICK_CYC  = 18'h00040;
    localparam logic [17:0] IDLE_EXIT_CYC   = 18'h00008;
    localparam int         SYNC_W          = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [2:0] {
        PDW_RUN,
        PDW_SLEEP,
        PDW_STANDBY,
        PDW_STAB,
        PDW_IDLE,
        PDW_IDLE_WAIT
    } pdw_state_t;

    typedef struct packed {
        logic       nmi_n;
        logic [2:0] irq_n;
        logic       bus_request_in_n;
    } pdw_pins_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } pdw_io_req_t;

    typedef struct packed {
        logic osc_en;
        logic cpu_clk_en;
        logic system_clock_output_en;
        logic periph_stop;
    } pdw_pwr_t;

endpackage

// ---- src/pdw_stab_timer.sv ----
`timescale 1ns/1ps

module pdw_stab_timer (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       arst_n,
    // Control
    input  wire logic                       load,
    input  wire logic [pdw_pkg::TMR_W-1:0]  load_val,
    input  wire logic                       run,
    // Status
    output logic                            done
);
    import pdw_pkg::*;

    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;
    logic             done_d;

    // Done pulses in the cycle after the last counted oscillator cycle.
    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (load) begin
            cnt_d = load_val;
        end else if (run && cnt_q != '0) begin
            cnt_d  = cnt_q - 1'b1;
            done_d = (cnt_q == {{(TMR_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            done  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done  <= done_d;
        end
    end

endmodule

// ---- src/pdw_sync.sv ----
`timescale 1ns/1ps

module pdw_sync (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        arst_n,
    // Data
    input  wire logic [pdw_pkg::SYNC_W-1:0]  din,
    output logic      [pdw_pkg::SYNC_W-1:0]  dout
);
    import pdw_pkg::*;

    // Pins idle high, so both stages reset high to avoid a false wake.
    logic [SYNC_W-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_bit
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    meta_q[i] <= 1'b1;
                    dout[i]   <= 1'b1;
                end else begin
                    meta_q[i] <= din[i];
                    dout[i]   <= meta_q[i];
                end
            end
        end
    endgenerate

endmodule

// ---- tb/pdw_ctrl_monitor.sv ----
`timescale 1ns/1ps

module pdw_ctrl_monitor
    import pdw_pkg::*;
#(
    parameter logic [17:0] STAB_NORMAL_CYC = pdw_pkg::STAB_NORMAL_DEF
) (
    // Clock and reset
    input wire logic                 clk_sys,
    input wire logic                 arst_n,
    // Controller inputs
    input wire pdw_pkg::pdw_pins_t   pins,
    input wire logic                 sleep_exec,
    input wire logic                 global_irq_enable_flag,
    input wire pdw_pkg::pdw_io_req_t io_req,
    // Controller outputs
    input wire logic                 io_hit,
    input wire logic [7:0]           io_rdata,
    input wire pdw_pkg::pdw_pwr_t    pwr,
    input wire pdw_pkg::pdw_state_t  mode,
    input wire logic                 nmi_ack_start,
    input wire logic [2:0]           irq_ack_start,
    input wire logic                 resume_next,
    input wire logic                 bus_grant
);
    import pdw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Cycles spent waiting for the oscillator, so the wait can be bounded.
    logic [17:0] stab_q;
    logic [17:0] stab_d;

    always_comb begin
        stab_d = (mode == PDW_STAB) ? stab_q + 18'h00001 : 18'h00000;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stab_q <= 18'h00000;
        end else begin
            stab_q <= stab_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_window_high: assert property (
        (io_req.rd && io_req.addr[15:8] != 8'h00) |=> !io_hit)
        else $error("io_hit for address with nonzero high byte");
    a_stop_source: assert property (
        $changed(pwr.periph_stop) |-> ($past(io_req.wr) || $past(io_req.wr, 2)))
        else $error("periph_stop changed without a write");
    a_standby_osc: assert property (
        pwr.osc_en == (mode != PDW_STANDBY))
        else $error("oscillator enable disagrees with standby");
    a_idle_clocks: assert property (
        mode == PDW_IDLE |-> (pwr.osc_en && !pwr.cpu_clk_en && !pwr.system_clock_output_en))
        else $error("idle clock enables wrong");
    a_idle_exit: assert property (
        $rose(mode == PDW_IDLE_WAIT) |-> (mode == PDW_IDLE_WAIT)[*7] ##[1:4] (mode == PDW_RUN))
        else $error("idle exit not eight cycles");
    a_stab_bounds: assert property (
        (mode == PDW_RUN && $past(mode) == PDW_STAB)
        |-> (stab_q >= 18'h00040 && stab_q <= STAB_NORMAL_CYC + 18'h00008))
        else $error("stabilisation wait out of range");
    a_nmi_pulse: assert property (
        nmi_ack_start |-> (mode == PDW_RUN && $past(mode) != PDW_RUN) ##1 !nmi_ack_start)
        else $error("nmi acknowledge pulse misplaced");
    a_irq_exclusive: assert property (
        (irq_ack_start != 3'h0) |-> ($onehot(irq_ack_start) && !resume_next && !nmi_ack_start))
        else $error("resume actions overlap");
    a_resume_clocks: assert property (
        (nmi_ack_start || resume_next || irq_ack_start != 3'h0)
        |-> (pwr.cpu_clk_en && pwr.system_clock_output_en))
        else $error("resume without clocks");
endmodule

bind pdw_ctrl pdw_ctrl_monitor #(.STAB_NORMAL_CYC(STAB_NORMAL_CYC)) u_mon (
    .clk_sys(clk_sys), .arst_n(arst_n), .pins(pins), .sleep_exec(sleep_exec),
    .global_irq_enable_flag(global_irq_enable_flag), .io_req(io_req), .io_hit(io_hit),
    .io_rdata(io_rdata), .pwr(pwr), .mode(mode), .nmi_ack_start(nmi_ack_start),
    .irq_ack_start(irq_ack_start), .resume_next(resume_next), .bus_grant(bus_grant)
);

// ---- tb/pdw_far_side.sv ----
`timescale 1ns/1ps

module pdw_far_side (
    // Requests from the bench
    input  wire logic         nmi_req,
    input  wire logic [2:0]   irq_req,
    input  wire logic         bus_request_in_req,
    // Pins toward the controller
    output pdw_pkg::pdw_pins_t pins
);
    import pdw_pkg::*;

    // Lines idle high as with pull-ups. They follow the requests at once, so a
    // line moves on the falling edge at which the bench changes its request.
    always_comb begin
        pins.nmi_n    = !nmi_req;
        pins.irq_n    = ~irq_req;
        pins.bus_request_in_n = !bus_request_in_req;
    end
endmodule

// ---- tb/power_down_wake_controller_tb.sv ----
`timescale 1ns/1ps

module power_down_wake_controller_tb;
    import pdw_pkg::*;

    logic        clk_sys;
    logic        arst_n;
    pdw_pins_t   pins;
    logic        sleep_exec;
    logic        global_irq_enable_flag;
    pdw_io_req_t io_req;
    logic        io_hit;
    logic [7:0]  io_rdata;
    pdw_pwr_t    pwr;
    pdw_state_t  mode;
    logic        nmi_ack_start;
    logic [2:0]  irq_ack_start;
    logic        resume_next;
    logic        bus_grant;
    logic        nmi_req;
    logic [2:0]  irq_req;
    logic        bus_request_in_req;
    logic [1:0]  base;
    logic        seen_hit;
    logic [7:0]  seen_data;
    int          n_errors;
    int          num_checks;
    int          cyc;
    int          n;

    pdw_ctrl #(.STAB_NORMAL_CYC(18'h00064)) dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .pins(pins), .sleep_exec(sleep_exec),
        .global_irq_enable_flag(global_irq_enable_flag), .io_req(io_req), .io_hit(io_hit),
        .io_rdata(io_rdata), .pwr(pwr), .mode(mode), .nmi_ack_start(nmi_ack_start),
        .irq_ack_start(irq_ack_start), .resume_next(resume_next), .bus_grant(bus_grant)
    );

    pdw_far_side u_far (
        .nmi_req(nmi_req), .irq_req(irq_req),
        .bus_request_in_req(bus_request_in_req), .pins(pins)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Called at a falling edge; the strobe spans exactly one rising edge. The
    // answer is taken while it stands, then an idle cycle keeps calls apart.
    task automatic io_acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
        io_req = '{addr: a, wr: wr, rd: !wr, wdata: d};
        @(negedge clk_sys);
        io_req    = '0;
        seen_hit  = io_hit;
        seen_data = io_rdata;
        @(negedge clk_sys);
    endtask

    task automatic io_rd(input logic [15:0] a, input logic hit, input logic [7:0] exp);
        io_acc(1'b0, a, 8'h00);
        chk("io_hit", hit, seen_hit);
        chk("io_rdata", exp, seen_data);
    endtask

    task automatic go_sleep(input logic [7:0] cpu_control, input logic [7:0] irq_trap_control, input pdw_state_t m);
        io_acc(1'b1, 16'h001F, cpu_control);
        io_acc(1'b1, 16'h0034, irq_trap_control);
        sleep_exec = 1'b1;
        @(negedge clk_sys);
        sleep_exec = 1'b0;
        chk("mode", m, mode);
    endtask

    task automatic stay(input int k, input pdw_state_t m);
        repeat (k) @(negedge clk_sys);
        chk("mode", m, mode);
    endtask

    // Pulses stand one cycle, so they are read at the first cycle back in run.
    task automatic wait_run(input int lim, input logic nmi, input logic [2:0] ack,
                            input logic nxt);
        n = 0;
        while (mode !== PDW_RUN && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        chk("mode", PDW_RUN, mode);
        chk("nmi_ack_start", nmi, nmi_ack_start);
        chk("irq_ack_start", ack, irq_ack_start);
        chk("resume_next", nxt, resume_next);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            $display("MISMATCH timeout expected done seen running");
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        sleep_exec = 1'b0;
        global_irq_enable_flag = 1'b1;
        io_req = '0;
        nmi_req = 1'b0;
        irq_req = 3'h0;
        bus_request_in_req = 1'b0;
        base = 2'h0;
        repeat (8) @(negedge clk_sys);
        arst_n = 1'b1;
        @(negedge clk_sys);
        io_rd(16'h003F, 1'b1, 8'h00);
        io_rd(16'h001F, 1'b1, 8'h00);
        io_rd(16'h0034, 1'b1, 8'h00);
        io_rd(16'h013F, 1'b0, 8'h00);
        io_rd(16'h0035, 1'b0, 8'h00);
        for (int i = 1; i <= 4; i++) begin
            io_acc(1'b1, {8'h00, base, 6'h3F}, {i[1:0], 6'h3F});
            base = i[1:0];
            io_rd({8'h00, base, 6'h3F}, 1'b1, {base, 6'h20});
            io_rd({8'h00, base ^ 2'h1, 6'h3F}, 1'b0, 8'h00);
        end
        chk("periph_stop", 1'b1, pwr.periph_stop);
        io_acc(1'b1, 16'h003F, 8'h00);
        io_rd(16'h003F, 1'b1, 8'h00);
        chk("periph_stop", 1'b0, pwr.periph_stop);
        io_acc(1'b1, 16'h003F, 8'h20);
        $display("test registers done");

        go_sleep(8'h48, 8'h01, PDW_STANDBY);
        irq_req = 3'h1;
        wait_run(200, 1'b0, 3'h1, 1'b0);
        chk("quick wait short", 1'b1, n < 90);
        irq_req = 3'h0;
        $display("test quick standby done");

        global_irq_enable_flag = 1'b0;
        go_sleep(8'h40, 8'h07, PDW_STANDBY);
        irq_req = 3'h2;
        wait_run(300, 1'b0, 3'h0, 1'b1);
        chk("normal wait long", 1'b1, n >= 100);
        irq_req = 3'h0;
        global_irq_enable_flag = 1'b1;
        $display("test normal standby done");

        go_sleep(8'h48, 8'h03, PDW_STANDBY);
        irq_req = 3'h4;
        stay(150, PDW_STANDBY);
        nmi_req = 1'b1;
        repeat (4) @(negedge clk_sys);
        nmi_req = 1'b0;
        wait_run(200, 1'b1, 3'h0, 1'b0);
        irq_req = 3'h0;
        $display("test nmi wake done");

        go_sleep(8'h40, 8'h01, PDW_STANDBY);
        irq_req = 3'h1;
        stay(20, PDW_STAB);
        irq_req = 3'h0;
        stay(150, PDW_STANDBY);
        irq_req = 3'h1;
        wait_run(300, 1'b0, 3'h1, 1'b0);
        chk("reloaded wait", 1'b1, n >= 100);
        irq_req = 3'h0;
        $display("test early release done");

        go_sleep(8'h08, 8'h01, PDW_IDLE);
        chk("cpu_clk_en", 1'b0, pwr.cpu_clk_en);
        irq_req = 3'h1;
        wait_run(30, 1'b0, 3'h1, 1'b0);
        chk("idle wait", 1'b1, n >= 8 && n <= 14);
        irq_req = 3'h0;
        $display("test idle done");

        // Bus request wakes standby only with its enable set, idle always.
        for (int k = 0; k < 2; k++) begin
            go_sleep((k == 1) ? 8'h08 : 8'h60, 8'h00,
                     (k == 1) ? PDW_IDLE : PDW_STANDBY);
            bus_request_in_req = 1'b1;
            wait_run(300, 1'b0, 3'h0, 1'b1);
            chk("bus_grant", 1'b1, bus_grant);
            bus_request_in_req = 1'b0;
            stay(4, PDW_RUN);
            chk("bus_grant", 1'b0, bus_grant);
        end
        $display("test bus request done");

        io_acc(1'b1, 16'h003F, 8'h00);
        go_sleep(8'h00, 8'h01, PDW_SLEEP);
        chk("periph_stop", 1'b0, pwr.periph_stop);
        irq_req = 3'h1;
        wait_run(10, 1'b0, 3'h1, 1'b0);
        irq_req = 3'h0;
        $display("test sleep done");
        test_done();
    end
endmodule
